//--- hdl/fsp_guard_decode.sv
// Guarded-region decoder: says whether an array address is shielded.
// Pure combinational; fed from the status register fields.
`timescale 1ns/1ps
module fsp_guard_decode #(
  parameter int ADDR_W = fsp_pkg::ARRAY_ADDR_W
) (
  input wire logic [4:0] guard_i,
  input wire logic invert_i,
  input wire logic [ADDR_W-1:0] addr_i,
  output logic hit_o
);

  logic [2:0] sel;
  logic [4:0] shift;
  logic [ADDR_W-1:0] mask;
  logic region;

  // Largest region spans bit 22, so fewer bits cannot be served
  if (ADDR_W < fsp_pkg::ARRAY_ADDR_W) begin : g_bad_width
    $error("fsp_guard_decode: ADDR_W too small");
  end

  // Region size as a power of two
  always_comb begin
    sel = guard_i[2:0];
    if (guard_i[4]) begin
      shift = 5'(fsp_pkg::SECTOR_SHIFT_BASE) + {2'h0, sel};
      if (shift > 5'(fsp_pkg::SECTOR_SHIFT_MAX)) begin
        shift = 5'(fsp_pkg::SECTOR_SHIFT_MAX);
      end
    end else begin
      shift = 5'(fsp_pkg::BLOCK_SHIFT_BASE) + {2'h0, sel};
    end
  end

  // One mask bit per address bit above the region size
  for (genvar b = 0; b < ADDR_W; b++) begin : g_mask
    assign mask[b] = (b >= int'(shift));
  end

  always_comb begin
    if (sel == 3'h0) begin
      region = 1'b0;
    end else if (sel == 3'h7) begin
      region = 1'b1;
    end else if (guard_i[3]) begin
      region = ((addr_i & mask) == '0);
    end else begin
      region = ((addr_i & mask) == mask);
    end
    hit_o = region ^ invert_i;
  end

endmodule

//--- hdl/fsp_pkg.sv
// Shared constants for the flash status and protection register bank.
// Assumes one 200 MHz clock; opcodes arrive already decoded from the
// serial command front end.
package fsp_pkg;

  // Array geometry: 8 MB needs 23 address bits
  localparam int ARRAY_ADDR_W = 23;
  localparam int BLOCK_SHIFT_BASE = 16;
  localparam int SECTOR_SHIFT_BASE = 11;
  localparam int SECTOR_SHIFT_MAX = 15;

  // Command opcodes
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
  localparam logic [7:0] OP_SREG_WR_LOW = 8'h01;
  localparam logic [7:0] OP_SREG_WR_MID = 8'h31;
  localparam logic [7:0] OP_SREG_WR_HIGH = 8'h11;
  localparam logic [7:0] OP_PAGE_WR = 8'h02;
  localparam logic [7:0] OP_PAGE_WR_QUAD = 8'h32;
  localparam logic [7:0] OP_PAGE_WR_FAST = 8'hf2;
  localparam logic [7:0] OP_SECTOR_WIPE = 8'h20;
  localparam logic [7:0] OP_BLOCK_WIPE = 8'h52;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;

  // Field positions inside the three status bytes
  localparam int LOW_BUSY_BIT = 0;
  localparam int LOW_WEL_BIT = 1;
  localparam int LOW_GUARD_LSB = 2;
  localparam int LOW_SRP_LO_BIT = 7;
  localparam int MID_SRP_HI_BIT = 0;
  localparam int MID_QE_BIT = 1;
  localparam int MID_PPAUSE_BIT = 2;
  localparam int MID_LOCK_LSB = 3;
  localparam int MID_INVERT_BIT = 6;
  localparam int MID_EPAUSE_BIT = 7;
  localparam int HIGH_FAST_BIT = 4;
  localparam int HIGH_DRV_LSB = 5;

  // Values after reset
  localparam logic [4:0] RST_GUARD = 5'h00;
  localparam logic [1:0] RST_SRP = 2'h0;
  localparam logic RST_QE = 1'b0;
  localparam logic [2:0] RST_LOCKS = 3'h0;
  localparam logic RST_INVERT = 1'b0;
  localparam logic [1:0] RST_DRV = 2'h1;

  // Status-guard modes
  localparam logic [1:0] SRP_SOFT = 2'h0;
  localparam logic [1:0] SRP_HW = 2'h1;
  localparam logic [1:0] SRP_SUPPLY = 2'h2;
  localparam logic [1:0] SRP_OTP = 2'h3;

  // Status write busy time, rounded up to whole cycles
  localparam int CLK_MHZ = 200;
  localparam int SREG_WRITE_NS = 1000;
  localparam int SREG_WRITE_CYC = (SREG_WRITE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    FSP_ST_IDLE = 2'b00,
    FSP_ST_ENGINE = 2'b01,
    FSP_ST_PAUSED = 2'b11,
    FSP_ST_SREG = 2'b10
  } fsp_state_t;

endpackage

//--- hdl/fsp_status_regs.sv
// Status and protection register bank of a serial NOR flash.
// Assumes a command front end that hands over one decoded command per
// cycle, and array engines that report busy on this same clock.
`timescale 1ns/1ps
module fsp_status_regs #(
  parameter logic [7:0] CHIP_WIPE_OP = 8'h00,
  parameter int SREG_WRITE_CYC = fsp_pkg::SREG_WRITE_CYC
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_op_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic [23:0] cmd_addr_i,
  input wire logic wp_n_i,
  input wire logic engine_busy_i,
  input wire logic engine_erasing_i,
  input wire logic engine_programming_i,
  input wire logic fast_mode_i,
  output logic [7:0] status_low_o,
  output logic [7:0] status_mid_o,
  output logic [7:0] status_high_o,
  output logic prog_start_o,
  output logic erase_start_o,
  output logic [7:0] op_code_o,
  output logic [23:0] op_addr_o,
  output logic refused_o,
  output logic suspend_o,
  output logic resume_o,
  output logic quad_lanes_o,
  output logic [1:0] drive_level_o
);

  localparam int CNT_W = $clog2(SREG_WRITE_CYC + 1);
  // Counter must hold at least one cycle of busy time
  if (SREG_WRITE_CYC < 1) begin : g_bad_cyc
    $error("fsp_status_regs: SREG_WRITE_CYC must be at least 1");
  end

  // Reset release and pin synchronisers
  logic rst_meta_q;
  logic rst_n_q;
  logic wp_meta_q;
  logic wp_sync_q;
  // Status fields
  logic busy_q;
  logic wel_q;
  logic [4:0] guard_q;
  logic [1:0] srp_q;
  logic qe_q;
  logic [2:0] locks_q;
  logic invert_q;
  logic epause_q;
  logic ppause_q;
  logic fast_q;
  logic [1:0] drv_q;
  // Sequencing
  fsp_pkg::fsp_state_t st_q;
  fsp_pkg::fsp_state_t st_d;
  logic [CNT_W-1:0] cnt_q;
  logic prog_start_q;
  logic erase_start_q;
  logic [7:0] op_code_q;
  logic [23:0] op_addr_q;
  logic refused_q;
  logic suspend_q;
  logic resume_q;
  // Decoded command terms
  logic is_sreg_wr;
  logic is_prog;
  logic is_wipe;
  logic is_chip;
  logic is_guarded_cmd;
  logic idle;
  logic wp_level;
  logic sreg_locked;
  logic guard_hit;
  logic sreg_ok;
  logic prog_ok;
  logic wipe_ok;
  logic chip_ok;
  logic launch;
  // Asynchronous assert, two-stage synchronous release
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Guard pin through two flops
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wp_meta_q <= 1'b1;
      wp_sync_q <= 1'b1;
    end else begin
      wp_meta_q <= wp_n_i;
      wp_sync_q <= wp_meta_q;
    end
  end

  // Region shield lookup for the addressed location
  fsp_guard_decode #(
    .ADDR_W(fsp_pkg::ARRAY_ADDR_W)
  ) u_guard (
    .guard_i(guard_q),
    .invert_i(invert_q),
    .addr_i(cmd_addr_i[fsp_pkg::ARRAY_ADDR_W-1:0]),
    .hit_o(guard_hit)
  );

  // Command classes
  always_comb begin
    is_sreg_wr = (cmd_op_i == fsp_pkg::OP_SREG_WR_LOW) ||
                 (cmd_op_i == fsp_pkg::OP_SREG_WR_MID) ||
                 (cmd_op_i == fsp_pkg::OP_SREG_WR_HIGH);
    is_prog = (cmd_op_i == fsp_pkg::OP_PAGE_WR) ||
              (cmd_op_i == fsp_pkg::OP_PAGE_WR_QUAD) ||
              (cmd_op_i == fsp_pkg::OP_PAGE_WR_FAST);
    is_wipe = (cmd_op_i == fsp_pkg::OP_SECTOR_WIPE) ||
              (cmd_op_i == fsp_pkg::OP_BLOCK_WIPE);
    is_chip = (cmd_op_i == CHIP_WIPE_OP);
    is_guarded_cmd = is_sreg_wr || is_prog || is_wipe || is_chip;
    idle = (st_q == fsp_pkg::FSP_ST_IDLE);
  end

  // Four-lane mode frees pin
  // With four lanes on, the guard pin carries data and protects nothing.
  assign wp_level = qe_q ? 1'b1 : wp_sync_q;

  always_comb begin
    unique case (srp_q)
      fsp_pkg::SRP_SOFT: sreg_locked = 1'b0;
      fsp_pkg::SRP_HW: sreg_locked = !wp_level;
      fsp_pkg::SRP_SUPPLY: sreg_locked = 1'b1;
      fsp_pkg::SRP_OTP: sreg_locked = 1'b1;
    endcase
  end

  always_comb begin
    sreg_ok = cmd_valid_i && is_sreg_wr && idle && wel_q && !sreg_locked;
    prog_ok = cmd_valid_i && is_prog && idle && wel_q && !guard_hit &&
              (qe_q || (cmd_op_i != fsp_pkg::OP_PAGE_WR_QUAD));
    wipe_ok = cmd_valid_i && is_wipe && idle && wel_q && !guard_hit;
    chip_ok = cmd_valid_i && is_chip && idle && wel_q &&
              (guard_q[2:0] == 3'h0) && !invert_q;
    launch = prog_ok || wipe_ok || chip_ok;
  end

  // Unlock sets latch
  // Accepted writes and the lock command drop it again.
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wel_q <= 1'b0;
    end else if (sreg_ok || launch) begin
      wel_q <= 1'b0;
    end else if (cmd_valid_i && idle) begin
      if (cmd_op_i == fsp_pkg::OP_WRITE_UNLOCK) begin
        wel_q <= 1'b1;
      end else if (cmd_op_i == fsp_pkg::OP_WRITE_LOCK) begin
        wel_q <= 1'b0;
      end
    end
  end

  // Guard field write
  // Low byte: guard field and low mode bit; bits 1..0 are read-only.
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      guard_q <= fsp_pkg::RST_GUARD;
      srp_q[0] <= fsp_pkg::RST_SRP[0];
    end else if (sreg_ok && (cmd_op_i == fsp_pkg::OP_SREG_WR_LOW)) begin
      guard_q <= cmd_data_i[fsp_pkg::LOW_GUARD_LSB +: 5];
      srp_q[0] <= cmd_data_i[fsp_pkg::LOW_SRP_LO_BIT];
    end
  end

  // Invert bit write
  // Mid byte: paused flags at bits 7 and 2 are read-only here.
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      srp_q[1] <= fsp_pkg::RST_SRP[1];
      qe_q <= fsp_pkg::RST_QE;
      locks_q <= fsp_pkg::RST_LOCKS;
      invert_q <= fsp_pkg::RST_INVERT;
    end else if (sreg_ok && (cmd_op_i == fsp_pkg::OP_SREG_WR_MID)) begin
      srp_q[1] <= cmd_data_i[fsp_pkg::MID_SRP_HI_BIT];
      qe_q <= cmd_data_i[fsp_pkg::MID_QE_BIT];
      locks_q <= locks_q | cmd_data_i[fsp_pkg::MID_LOCK_LSB +: 3];
      invert_q <= cmd_data_i[fsp_pkg::MID_INVERT_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      drv_q <= fsp_pkg::RST_DRV;
    end else if (sreg_ok && (cmd_op_i == fsp_pkg::OP_SREG_WR_HIGH)) begin
      drv_q <= cmd_data_i[fsp_pkg::HIGH_DRV_LSB +: 2];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fast_q <= 1'b0;
    end else begin
      fast_q <= fast_mode_i;
    end
  end

  // Operation sequencer
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      fsp_pkg::FSP_ST_IDLE: begin
        if (sreg_ok) begin
          st_d = fsp_pkg::FSP_ST_SREG;
        end else if (launch) begin
          st_d = fsp_pkg::FSP_ST_ENGINE;
        end
      end
      fsp_pkg::FSP_ST_SREG: begin
        if (cnt_q == CNT_W'(1)) begin
          st_d = fsp_pkg::FSP_ST_IDLE;
        end
      end
      fsp_pkg::FSP_ST_ENGINE: begin
        if (cmd_valid_i && (cmd_op_i == fsp_pkg::OP_SUSPEND) &&
            (engine_erasing_i || engine_programming_i)) begin
          st_d = fsp_pkg::FSP_ST_PAUSED;
        end else if (!engine_busy_i && !prog_start_q && !erase_start_q &&
                     !resume_q) begin
          st_d = fsp_pkg::FSP_ST_IDLE;
        end
      end
      fsp_pkg::FSP_ST_PAUSED: begin
        if (cmd_valid_i && (cmd_op_i == fsp_pkg::OP_RESUME)) begin
          st_d = fsp_pkg::FSP_ST_ENGINE;
        end
      end
    endcase
  end

  // State register and status write timer
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= fsp_pkg::FSP_ST_IDLE;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      if (sreg_ok) begin
        cnt_q <= CNT_W'(SREG_WRITE_CYC);
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (st_d == fsp_pkg::FSP_ST_SREG) ||
                (st_d == fsp_pkg::FSP_ST_ENGINE);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      epause_q <= 1'b0;
      ppause_q <= 1'b0;
    end else if (st_q == fsp_pkg::FSP_ST_ENGINE &&
                 st_d == fsp_pkg::FSP_ST_PAUSED) begin
      epause_q <= engine_erasing_i;
      ppause_q <= engine_programming_i && !engine_erasing_i;
    end else if (st_q == fsp_pkg::FSP_ST_PAUSED &&
                 st_d == fsp_pkg::FSP_ST_ENGINE) begin
      epause_q <= 1'b0;
      ppause_q <= 1'b0;
    end
  end

  // Engine start, suspend and resume pulses with operands
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prog_start_q <= 1'b0;
      erase_start_q <= 1'b0;
      suspend_q <= 1'b0;
      resume_q <= 1'b0;
      op_code_q <= 8'h00;
      op_addr_q <= 24'h00_0000;
    end else begin
      prog_start_q <= prog_ok;
      erase_start_q <= wipe_ok || chip_ok;
      suspend_q <= (st_q == fsp_pkg::FSP_ST_ENGINE) &&
                   (st_d == fsp_pkg::FSP_ST_PAUSED);
      resume_q <= (st_q == fsp_pkg::FSP_ST_PAUSED) &&
                  (st_d == fsp_pkg::FSP_ST_ENGINE);
      if (launch) begin
        op_code_q <= cmd_op_i;
        op_addr_q <= cmd_addr_i;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= cmd_valid_i && is_guarded_cmd && !sreg_ok && !launch;
    end
  end

  assign status_low_o = {srp_q[0], guard_q, wel_q, busy_q};
  assign status_mid_o = {epause_q, invert_q, locks_q, ppause_q, qe_q,
                         srp_q[1]};
  assign status_high_o = {1'b0, drv_q, fast_q, 4'h0};

  // Engine and pad control outputs
  assign prog_start_o = prog_start_q;
  assign erase_start_o = erase_start_q;
  assign op_code_o = op_code_q;
  assign op_addr_o = op_addr_q;
  assign refused_o = refused_q;
  assign suspend_o = suspend_q;
  assign resume_o = resume_q;
  assign quad_lanes_o = qe_q;
  assign drive_level_o = drv_q;

endmodule

//--- test/fsp_engine_model.sv
// Array engine model standing behind the register bank.
// Answers launches after dly_i cycles; freezes while paused.
`timescale 1ns/1ps
module fsp_engine_model (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic prog_start_i,
  input wire logic erase_start_i,
  input wire logic suspend_i,
  input wire logic resume_i,
  input wire logic [7:0] dly_i,
  output logic busy_o,
  output logic erasing_o,
  output logic programming_o
);
  logic [7:0] cnt_q;
  logic ers_q;
  logic paused_q;
  // Run count, kind and pause state
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= 8'h00;
      ers_q <= 1'b0;
      paused_q <= 1'b0;
    end else if (prog_start_i || erase_start_i) begin
      cnt_q <= dly_i;
      ers_q <= erase_start_i;
    end else if (suspend_i) begin
      paused_q <= 1'b1;
    end else if (resume_i) begin
      paused_q <= 1'b0;
    end else if (!paused_q && cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  // Busy only while running and not paused
  assign busy_o = cnt_q != 8'h00 && !paused_q;
  assign erasing_o = ers_q && cnt_q != 8'h00;
  assign programming_o = !ers_q && cnt_q != 8'h00;
endmodule

//--- test/fsp_status_regs_asserts.sv
// Checker for the status and protection register bank.
// Sees only the top ports; attached by the bind at the foot.
`timescale 1ns/1ps
module fsp_status_regs_chk #(
  parameter logic [7:0] CHIP_WIPE_OP = 8'h00
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_op_i,
  input wire logic wp_n_i,
  input wire logic [7:0] status_low_o,
  input wire logic [7:0] status_mid_o,
  input wire logic [7:0] status_high_o,
  input wire logic prog_start_o,
  input wire logic erase_start_o,
  input wire logic refused_o,
  input wire logic suspend_o,
  input wire logic resume_o,
  input wire logic quad_lanes_o
);
  logic idle;
  logic wr;
  // Idle and status write decode
  assign idle = !status_low_o[0] && !status_mid_o[7] && !status_mid_o[2];
  assign wr = cmd_valid_i && (cmd_op_i == fsp_pkg::OP_SREG_WR_LOW ||
    cmd_op_i == fsp_pkg::OP_SREG_WR_MID ||
    cmd_op_i == fsp_pkg::OP_SREG_WR_HIGH);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  property p_launch;
    prog_start_o || erase_start_o |->
      status_low_o[0] && !status_low_o[1] && $past(status_low_o[1]);
  endproperty
  a_launch: assert property (p_launch)
    else $error("launch flags wrong");
  property p_nowel;
    wr && idle && !status_low_o[1] |=> refused_o;
  endproperty
  a_nowel: assert property (p_nowel)
    else $error("write without latch not refused");
  property p_unlock;
    cmd_valid_i && cmd_op_i == fsp_pkg::OP_WRITE_UNLOCK && idle
      |=> status_low_o[1];
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock did not set latch");
  property p_soft;
    wr && idle && status_low_o[1] && !status_low_o[7] && !status_mid_o[0]
      |=> status_low_o[0] && !status_low_o[1] && !refused_o;
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft mode write not taken");
  property p_hwlock;
    (!wp_n_i) [*4] ##0 (wr && idle && status_low_o[1] && status_low_o[7]
      && !status_mid_o[0] && !status_mid_o[1]) |=> refused_o;
  endproperty
  a_hwlock: assert property (p_hwlock)
    else $error("pin lock not honoured");
  property p_sreg_guard_mode_hi;
    wr && idle && status_low_o[1] && status_mid_o[0] |=> refused_o;
  endproperty
  a_sreg_guard_mode_hi: assert property (p_sreg_guard_mode_hi)
    else $error("locked mode write not refused");
  property p_chip;
    cmd_valid_i && cmd_op_i == CHIP_WIPE_OP && idle && status_low_o[1] &&
      (status_low_o[4:2] != 3'h0 || status_mid_o[6])
      |=> refused_o && !erase_start_o;
  endproperty
  a_chip: assert property (p_chip)
    else $error("guarded chip erase launched");
  property p_locks;
    1'b1 |=> (status_mid_o[5:3] & $past(status_mid_o[5:3]))
      == $past(status_mid_o[5:3]);
  endproperty
  a_locks: assert property (p_locks)
    else $error("lock bit cleared");
  property p_susp;
    suspend_o |-> (status_mid_o[7] ^ status_mid_o[2]) && !status_low_o[0];
  endproperty
  a_susp: assert property (p_susp)
    else $error("suspend flags wrong");
  property p_resume;
    resume_o |-> !status_mid_o[7] && !status_mid_o[2] && status_low_o[0];
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume flags wrong");
  property p_resv;
    status_high_o[7] == 1'b0 && status_high_o[3:0] == 4'h0 &&
      quad_lanes_o == status_mid_o[1];
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved bits or lanes wrong");
endmodule
bind fsp_status_regs fsp_status_regs_chk #(
  .CHIP_WIPE_OP(CHIP_WIPE_OP)
) chk_u (
  .clock_i(clock_i),
  .resetn_i(resetn_i),
  .cmd_valid_i(cmd_valid_i),
  .cmd_op_i(cmd_op_i),
  .wp_n_i(wp_n_i),
  .status_low_o(status_low_o),
  .status_mid_o(status_mid_o),
  .status_high_o(status_high_o),
  .prog_start_o(prog_start_o),
  .erase_start_o(erase_start_o),
  .refused_o(refused_o),
  .suspend_o(suspend_o),
  .resume_o(resume_o),
  .quad_lanes_o(quad_lanes_o)
);

//--- test/fsp_status_regs_tb.sv
// Self-checking bench for the status and protection register bank.
// Commands driven at the falling edge; an engine model answers.
`timescale 1ns/1ps
module fsp_status_regs_tb;
  localparam logic [7:0] CHIP = 8'hc7;
  localparam logic [7:0] UNL = fsp_pkg::OP_WRITE_UNLOCK;
  localparam logic [7:0] WL = fsp_pkg::OP_SREG_WR_LOW;
  localparam logic [7:0] WM = fsp_pkg::OP_SREG_WR_MID;
  localparam logic [7:0] WH = fsp_pkg::OP_SREG_WR_HIGH;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [7:0] cmd_op_i = 8'h00;
  logic [7:0] cmd_data_i = 8'h00;
  logic [23:0] cmd_addr_i = 24'h00_0000;
  logic wp_n_i = 1'b1;
  logic fast_mode_i = 1'b0;
  logic [7:0] dly = 8'h04;
  logic eng_busy, eng_ers, eng_prg;
  logic [7:0] status_low_o, status_mid_o, status_high_o, op_code_o, seen;
  logic [23:0] op_addr_o;
  logic prog_start_o, erase_start_o, refused_o, suspend_o, resume_o;
  logic quad_lanes_o;
  logic [1:0] drive_level_o;
  logic [7:0] exp_q[$];
  logic [7:0] ops [0:3] = '{fsp_pkg::OP_PAGE_WR, fsp_pkg::OP_SECTOR_WIPE,
    fsp_pkg::OP_BLOCK_WIPE, CHIP};
  logic [32:0] tbl [0:9];
  logic [32:0] e;
  logic [31:0] r;
  logic [7:0] v;
  logic [31:0] seed = 32'h0000_615c;
  int n_mismatch = 0;
  int comparisons = 0;
  fsp_status_regs #(.CHIP_WIPE_OP(CHIP), .SREG_WRITE_CYC(2)) dut_u (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i),
    .cmd_data_i(cmd_data_i),
    .cmd_addr_i(cmd_addr_i),
    .wp_n_i(wp_n_i),
    .engine_busy_i(eng_busy),
    .engine_erasing_i(eng_ers),
    .engine_programming_i(eng_prg),
    .fast_mode_i(fast_mode_i),
    .status_low_o(status_low_o),
    .status_mid_o(status_mid_o),
    .status_high_o(status_high_o),
    .prog_start_o(prog_start_o),
    .erase_start_o(erase_start_o),
    .op_code_o(op_code_o),
    .op_addr_o(op_addr_o),
    .refused_o(refused_o),
    .suspend_o(suspend_o),
    .resume_o(resume_o),
    .quad_lanes_o(quad_lanes_o),
    .drive_level_o(drive_level_o)
  );
  fsp_engine_model eng_u (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .prog_start_i(prog_start_o),
    .erase_start_i(erase_start_o),
    .suspend_i(suspend_o),
    .resume_i(resume_o),
    .dly_i(dly),
    .busy_o(eng_busy),
    .erasing_o(eng_ers),
    .programming_o(eng_prg)
  );
  // Clock at 200 MHz
  always #2.5 clock_i = ~clock_i;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(string nm, logic [7:0] x, logic [7:0] s);
    comparisons++;
    if (s !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic chk_addr(string nm, logic [23:0] x, logic [23:0] s);
    comparisons++;
    if (s !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cmd(logic [7:0] op, logic [7:0] d, logic [23:0] a);
    @(negedge clock_i);
    cmd_valid_i = 1'b1;
    cmd_op_i = op;
    cmd_data_i = d;
    cmd_addr_i = a;
    @(negedge clock_i);
    cmd_valid_i = 1'b0;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 400 && status_low_o[0] !== 1'b0; i++) begin
      @(negedge clock_i);
    end
  endtask
  task automatic do_reset();
    resetn_i = 1'b0;
    repeat (5) @(negedge clock_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clock_i);
  endtask
  // Unlock, then status write; a refusal is noted first
  task automatic wsr(logic [7:0] op, logic [7:0] d, logic [7:0] rc);
    r = rnd();
    cmd(UNL, r[7:0], r[31:8]);
    if (rc != 8'h00) exp_q.push_back(rc);
    cmd(op, d, 24'h00_0000);
    if (rc == 8'h00) chk("busy", 8'h01, {7'h0, status_low_o[0]});
    wait_idle();
  endtask
  // Compare each launch or refusal pulse with the oldest note
  assign seen = {5'h0, refused_o, erase_start_o, prog_start_o};
  always @(negedge clock_i) begin
    if (seen !== 8'h00) begin
      if (exp_q.size() == 0) chk("pulse", 8'h00, seen);
      else chk("pulse", exp_q.pop_front(), seen);
    end
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    conclude();
  end
  initial begin
    tbl = '{
      {2'd0, 5'h01, 2'b00, 24'h7f_0000}, {2'd1, 5'h01, 2'b01, 24'h01_0000},
      {2'd2, 5'h01, 2'b11, 24'h7f_0000}, {2'd0, 5'h01, 2'b10, 24'h01_0000},
      {2'd1, 5'h00, 2'b10, 24'h40_0000}, {2'd2, 5'h07, 2'b11, 24'h40_0000},
      {2'd0, 5'h07, 2'b00, 24'h00_0000}, {2'd3, 5'h18, 2'b01, 24'h00_0000},
      {2'd3, 5'h04, 2'b00, 24'h00_0000}, {2'd3, 5'h00, 2'b10, 24'h00_0000}};
    do_reset();
    chk("low", 8'h00, status_low_o);
    chk("mid", 8'h00, status_mid_o);
    chk("high", 8'h20, status_high_o);
    chk("pins", 8'h01, {5'h0, quad_lanes_o, drive_level_o});
    exp_q.push_back(8'h04);
    cmd(WL, 8'h7c, 24'h00_0000);
    chk("low", 8'h00, status_low_o);
    v = 8'(rnd()) & 8'h7f;
    wsr(WL, v, 8'h00);
    chk("low", v & 8'h7c, status_low_o);
    for (int i = 0; i < 4; i++) begin
      wsr(WH, {seed[7], i[1:0], seed[4:0]}, 8'h00);
      chk("high", {1'b0, i[1:0], 5'h00}, status_high_o);
      chk("drive", i[7:0], {6'h0, drive_level_o});
    end
    fast_mode_i = 1'b1;
    repeat (2) @(negedge clock_i);
    chk("fast", 8'h01, {7'h0, status_high_o[4]});
    fast_mode_i = 1'b0;
    // Guarded region table, all launch kinds
    foreach (tbl[k]) begin
      e = tbl[k];
      wsr(WL, {1'b0, e[30:26], 2'b00}, 8'h00);
      wsr(WM, {1'b0, e[25], 6'h00}, 8'h00);
      dly = 8'h02 + {4'h0, seed[3:0]};
      cmd(UNL, 8'h00, 24'h00_0000);
      exp_q.push_back(e[24] ? (e[32:31] == 2'd0 ? 8'h01 : 8'h02) : 8'h04);
      cmd(ops[e[32:31]], seed[15:8], e[23:0]);
      if (e[24]) chk("op", ops[e[32:31]], op_code_o);
      if (e[24]) chk_addr("addr", e[23:0], op_addr_o);
      wait_idle();
    end
    wsr(WM, 8'h08, 8'h00);
    wsr(WM, 8'h10, 8'h00);
    // paused flags at bits 7 and 2 ignore the write; only the four-lane bit takes
    wsr(WM, 8'h86, 8'h00);
    chk("mid", 8'h1a, status_mid_o);
    wsr(WM, 8'h00, 8'h00);
    chk("mid", 8'h18, status_mid_o);
    dly = 8'h40;
    for (int k = 0; k < 2; k++) begin
      cmd(UNL, 8'h00, 24'h00_0000);
      exp_q.push_back(k ? 8'h02 : 8'h01);
      cmd(ops[k], 8'h00, 24'h10_0000);
      cmd(fsp_pkg::OP_SUSPEND, 8'h00, 24'h00_0000);
      chk("mid", k ? 8'h98 : 8'h1c, status_mid_o);
      chk("low", 8'h00, status_low_o);
      cmd(fsp_pkg::OP_RESUME, 8'h00, 24'h00_0000);
      chk("mid", 8'h18, status_mid_o);
      wait_idle();
    end
    // Quad program needs four lanes; lock command drops the latch
    cmd(UNL, 8'h00, 24'h00_0000);
    exp_q.push_back(8'h04);
    cmd(fsp_pkg::OP_PAGE_WR_QUAD, 8'h00, 24'h00_0000);
    chk("low", 8'h02, status_low_o);
    cmd(fsp_pkg::OP_WRITE_LOCK, 8'h00, 24'h00_0000);
    chk("low", 8'h00, status_low_o);
    cmd(UNL, 8'h00, 24'h00_0000);
    exp_q.push_back(8'h01);
    cmd(fsp_pkg::OP_PAGE_WR_FAST, r[7:0], 24'h12_3456);
    chk("op", fsp_pkg::OP_PAGE_WR_FAST, op_code_o);
    chk_addr("addr", 24'h12_3456, op_addr_o);
    wait_idle();
    wp_n_i = 1'b0;
    wsr(WL, 8'h80, 8'h00);
    chk("low", 8'h80, status_low_o);
    wsr(WL, 8'h00, 8'h04);
    chk("low", 8'h82, status_low_o);
    wp_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    wsr(WL, 8'h00, 8'h00);
    chk("low", 8'h00, status_low_o);
    wsr(WM, 8'h01, 8'h00);
    wsr(WL, 8'h1c, 8'h04);
    chk("low", 8'h02, status_low_o);
    do_reset();
    chk("mid", 8'h00, status_mid_o);
    wsr(WL, 8'h80, 8'h00);
    wsr(WM, 8'h01, 8'h00);
    wsr(WM, 8'h00, 8'h04);
    chk("mid", 8'h01, status_mid_o);
    repeat (2) @(negedge clock_i);
    chk("queue", 8'h00, 8'(exp_q.size()));
    conclude();
  end
endmodule
